// ===== logic/scc_pkg.sv
// constants, field layouts and carrier types of the system control coprocessor
// How it works
// - status bit 23 locks instruction cache way A, bit 24 locks data cache way A.
// - a locked way whose selected line is valid is never picked as refill victim.
// - an invalid line in a locked way may still be refilled.
// - lock bits disable refill within 5 (instruction) and 3 (data) instructions.
// - status bit 26 selects 16 or 32 addressable float registers.
// - with that bit clear, any odd float register access traps.
// - cause bit 24 flags instruction watch, bit 25 flags data watch.
// - cause bit 23 resets clear; then all exceptions use offset 0x180.
// - with cause bit 23 set, interrupts use offset 0x200, others unchanged.
// - translation table operations are silent no-ops; offsets 0x000, 0x080 unused.
// - user mode checks addresses against base/bound; codes 0x2 instruction, 0x3 data.
// - kernel mode uses a fixed address mapping and never raises bound violations.
// - policy register has one field per 512 MB region, resets to 0x22233333.
// - an enabled watch match raises code 0x23 and sets the matching watch flag.
// - a pending watch exception is taken only while both level flags are clear.
// - checking may be skipped for 2 or 5 instructions after watch enable.
// - configuration register is read-only, both cache size fields read 001.
// - faulting address and both return program counters are 32 bits.
// - double precision float operations and doubleword float moves trap.
// - separate float multiply and add units let a multiply overlap an add.
// - the user bit selects user or kernel, but either level flag forces kernel; all coprocessor registers are 32 bits.
// - doubleword coprocessor moves are ignored without a trap.
package scc_pkg;
    // coprocessor register numbers
    localparam logic [4:0] REG_IBASE = 5'h00;
    localparam logic [4:0] REG_IBOUND = 5'h01;
    localparam logic [4:0] REG_DBASE = 5'h02;
    localparam logic [4:0] REG_DBOUND = 5'h03;
    localparam logic [4:0] REG_FAULTING_ADDRESS_REGISTER = 5'h08;
    localparam logic [4:0] REG_STATUS = 5'h0C;
    localparam logic [4:0] REG_CAUSE = 5'h0D;
    localparam logic [4:0] REG_EPC = 5'h0E;
    localparam logic [4:0] REG_CONFIG = 5'h10;
    localparam logic [4:0] REG_CACHE_POLICY_MAP = 5'h11;
    localparam logic [4:0] REG_INSTRUCTION_WATCHPOINT = 5'h12;
    localparam logic [4:0] REG_DATA_WATCHPOINT = 5'h13;
    localparam logic [4:0] REG_ERROR_RETURN_PC = 5'h1E;
    // status fields
    localparam int ST_IE = 0;
    localparam int ST_EXL = 1;
    localparam int ST_ERL = 2;
    localparam int ST_UM = 4;
    localparam int ST_IL = 23;
    localparam int ST_DL = 24;
    localparam int ST_FR = 26;
    localparam logic [31:0] STATUS_RST = 32'h0000_0004;
    // cause fields
    localparam int CA_CODE_LSB = 2;
    localparam int CA_CODE_W = 6;
    localparam int CA_IP = 8;
    localparam int CA_IV = 23;
    localparam int CA_IW = 24;
    localparam int CA_DW = 25;
    localparam logic [31:0] CAUSE_RST = 32'h0000_0000;
    // policy map, configuration and address mapping
    localparam logic [31:0] CACHE_POLICY_MAP_RST = 32'h2223_3333;
    localparam int CACHE_POLICY_MAP_FW = 4;
    localparam int REGION_LSB = 29;
    localparam logic [31:0] CONFIG_VAL = 32'h0000_0240;
    localparam logic [31:0] KMAP_MASK = 32'h1FFF_FFFF;
    localparam int WATCH_EN = 0;
    // vector offsets and exception codes
    localparam logic [11:0] VEC_GENERAL = 12'h180;
    localparam logic [11:0] VEC_INT = 12'h200;
    localparam logic [5:0] EXC_INT = 6'h00;
    localparam logic [5:0] EXC_IBOUND = 6'h02;
    localparam logic [5:0] EXC_DBOUND = 6'h03;
    localparam logic [5:0] EXC_FPTRAP = 6'h0F;
    localparam logic [5:0] EXC_WATCH = 6'h23;
    // float unit latencies
    localparam int FP_MUL_LAT = 4;
    localparam int FP_ADD_LAT = 4;

    typedef struct packed {
        logic valid;
        logic write;
        logic dword;
        logic [4:0] regnum;
        logic [31:0] wdata;
    } scc_cop_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } scc_access_t;

    typedef struct packed {
        logic valid;
        logic is_mul;
        logic is_double;
        logic is_dmove;
        logic [4:0] reg_idx;
    } scc_fp_t;

    typedef struct packed {
        logic req;
        logic valid_a;
        logic valid_b;
        logic lru_b;
    } scc_refill_t;
endpackage : scc_pkg

// ===== logic/scc_victim_sel.sv
// refill victim way selection honouring the way A lock
`timescale 1ns/1ps
module scc_victim_sel (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_lock,
    input wire scc_pkg::scc_refill_t i_refill,
    output logic o_victim_b
);
    import scc_pkg::*;

    logic victim_b_nxt;
    logic victim_b_r;

    // an empty way A is always refilled first, lock or not, so locked ways can be reloaded
    assign victim_b_nxt = !i_refill.valid_a ? 1'b0 :
                          i_lock ? 1'b1 :
                          !i_refill.valid_b ? 1'b1 : i_refill.lru_b;

    // choice is held until the next refill request
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            victim_b_r <= 1'b0;
        end else if (i_refill.req) begin
            victim_b_r <= victim_b_nxt;
        end
    end

    assign o_victim_b = victim_b_r;
endmodule : scc_victim_sel

// ===== logic/scc_fp_lane.sv
// one float execution lane with a fixed latency
`timescale 1ns/1ps
module scc_fp_lane #(
    parameter int unsigned LATENCY = 4
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_issue,
    output logic o_busy,
    output logic o_done
);
    import scc_pkg::*;

    localparam int CW = $clog2(LATENCY + 1);

    logic [CW-1:0] cnt_r;
    logic done_r;

    // not pipelined: a second issue to the same lane waits until the count runs out
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= (cnt_r == CW'(1));
            if (i_issue && cnt_r == '0) begin
                cnt_r <= CW'(LATENCY);
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - CW'(1);
            end
        end
    end

    assign o_busy = (cnt_r != '0);
    assign o_done = done_r;
endmodule : scc_fp_lane

// ===== logic/scc_ctrl.sv
// system control coprocessor: registers, checks, exception dispatch
`timescale 1ns/1ps
module scc_ctrl (
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    input wire scc_pkg::scc_cop_t I_COP,
    output logic [31:0] O_MFC_DATA,
    input wire logic I_TLB_OP,
    output logic O_TLB_DONE,
    input wire logic I_ERET,
    output logic [31:0] O_RETURN_PC,
    input wire scc_pkg::scc_access_t I_IFETCH,
    input wire scc_pkg::scc_access_t I_DATA,
    input wire logic [31:0] I_INSTR_PC,
    input wire logic I_INT_PEND,
    input wire scc_pkg::scc_fp_t I_FP,
    output logic O_FP_STALL,
    output logic O_FP_MUL_BUSY,
    output logic O_FP_ADD_BUSY,
    output logic O_FP_MUL_DONE,
    output logic O_FP_ADD_DONE,
    input wire scc_pkg::scc_refill_t I_IREFILL,
    input wire scc_pkg::scc_refill_t I_DREFILL,
    output logic O_IVICTIM_B,
    output logic O_DVICTIM_B,
    output logic O_KERNEL_MODE,
    output logic O_FR_MODE,
    output logic [31:0] O_IPHYS_ADDR,
    output logic [31:0] O_DPHYS_ADDR,
    output logic [3:0] O_IPOLICY,
    output logic [3:0] O_DPOLICY,
    output logic O_EXC_TAKE,
    output logic [11:0] O_EXC_VECTOR,
    output logic [5:0] O_EXC_CODE
);
    import scc_pkg::*;

    // policy field of the 512 MB region that holds an address
    function automatic logic [3:0] region_policy(input logic [31:0] map, input logic [31:0] addr);
        logic [2:0] region;
        region = addr[31:REGION_LSB];
        region_policy = map[region*CACHE_POLICY_MAP_FW +: CACHE_POLICY_MAP_FW];
    endfunction : region_policy

    logic [31:0] status_r, status_nxt;
    logic [31:0] cause_r, cause_nxt;
    logic [31:0] epc_r, error_return_pc_r, faulting_address_register_r;
    logic [31:0] cache_policy_map_r;
    logic [31:0] ibase_r, ibound_r, dbase_r, dbound_r;
    logic [31:0] instruction_watchpoint_r, data_watchpoint_r;
    logic [31:0] rd_data;
    logic [31:0] mfc_data_r;
    logic tlb_done_r;
    logic iw_pend_r, dw_pend_r;
    logic exc_take_r;
    logic [11:0] exc_vector_r;
    logic [5:0] exc_code_r;
    logic [31:0] iphys_r, dphys_r;
    logic [3:0] ipolicy_r, dpolicy_r;

    // move decode; doubleword moves are dropped silently, no write and no trap
    wire cop_wr = I_COP.valid && I_COP.write && !I_COP.dword;
    wire cop_rd = I_COP.valid && !I_COP.write && !I_COP.dword;
    wire we_status = cop_wr && (I_COP.regnum == REG_STATUS);
    wire we_cause = cop_wr && (I_COP.regnum == REG_CAUSE);
    wire we_epc = cop_wr && (I_COP.regnum == REG_EPC);
    wire we_error_return_pc = cop_wr && (I_COP.regnum == REG_ERROR_RETURN_PC);
    wire we_cache_policy_map = cop_wr && (I_COP.regnum == REG_CACHE_POLICY_MAP);
    wire we_ibase = cop_wr && (I_COP.regnum == REG_IBASE);
    wire we_ibound = cop_wr && (I_COP.regnum == REG_IBOUND);
    wire we_dbase = cop_wr && (I_COP.regnum == REG_DBASE);
    wire we_dbound = cop_wr && (I_COP.regnum == REG_DBOUND);
    wire we_instruction_watchpoint = cop_wr && (I_COP.regnum == REG_INSTRUCTION_WATCHPOINT);
    wire we_data_watchpoint = cop_wr && (I_COP.regnum == REG_DATA_WATCHPOINT);

    // privilege: user only when the user bit is set and no exception level is active
    wire st_exl = status_r[ST_EXL];
    wire st_erl = status_r[ST_ERL];
    wire kernel = !status_r[ST_UM] || st_exl || st_erl;
    wire fr_mode = status_r[ST_FR];

    // base/bound checks, user mode only
    wire ibnd_viol = !kernel && I_IFETCH.valid &&
                     (I_IFETCH.addr < ibase_r || I_IFETCH.addr > ibound_r);
    wire dbnd_viol = !kernel && I_DATA.valid &&
                     (I_DATA.addr < dbase_r || I_DATA.addr > dbound_r);

    // watch matches on word address; checking starts at once after enable
    wire iw_hit = instruction_watchpoint_r[WATCH_EN] && I_IFETCH.valid &&
                  (I_IFETCH.addr[31:2] == instruction_watchpoint_r[31:2]);
    wire dw_hit = data_watchpoint_r[WATCH_EN] && I_DATA.valid &&
                  (I_DATA.addr[31:2] == data_watchpoint_r[31:2]);
    wire iw_pend = iw_pend_r || iw_hit;
    wire dw_pend = dw_pend_r || dw_hit;
    wire watch_ok = !st_exl && !st_erl;

    // float traps: odd register in 16-register mode, any double work
    wire fp_odd = !fr_mode && I_FP.reg_idx[0];
    wire fp_trap = I_FP.valid && (fp_odd || I_FP.is_double || I_FP.is_dmove);
    wire int_take = I_INT_PEND && status_r[ST_IE] && watch_ok;

    // priority: bounds, float trap, watch, interrupt
    wire take_ib = ibnd_viol;
    wire take_db = !take_ib && dbnd_viol;
    wire take_fp = !take_ib && !take_db && fp_trap;
    wire take_iw = !take_ib && !take_db && !take_fp && watch_ok && iw_pend;
    wire take_dw = !take_ib && !take_db && !take_fp && !take_iw && watch_ok && dw_pend;
    wire take_int = !take_ib && !take_db && !take_fp && !take_iw && !take_dw && int_take;
    wire exc_take = take_ib || take_db || take_fp || take_iw || take_dw || take_int;
    wire [5:0] exc_code = take_ib ? EXC_IBOUND : take_db ? EXC_DBOUND :
                          take_fp ? EXC_FPTRAP : (take_iw || take_dw) ? EXC_WATCH : EXC_INT;
    // only two offsets exist; the old translation offsets are never produced
    wire [11:0] exc_vector = (take_int && cause_r[CA_IV]) ? VEC_INT : VEC_GENERAL;
    wire [31:0] exc_pc = take_ib || take_iw || take_int ? I_IFETCH.addr : I_INSTR_PC;

    // status and cause: hardware set beats a software write in the same cycle
    always_comb begin
        status_nxt = we_status ? I_COP.wdata : status_r;
        cause_nxt = cause_r;
        if (we_cause) begin
            cause_nxt[CA_IV] = I_COP.wdata[CA_IV];
            cause_nxt[CA_IW] = I_COP.wdata[CA_IW];
            cause_nxt[CA_DW] = I_COP.wdata[CA_DW];
        end
        if (I_ERET) begin
            if (st_erl) begin
                status_nxt[ST_ERL] = 1'b0;
            end else begin
                status_nxt[ST_EXL] = 1'b0;
            end
        end
        if (exc_take) begin
            status_nxt[ST_EXL] = 1'b1;
            cause_nxt[CA_CODE_LSB +: CA_CODE_W] = exc_code;
            cause_nxt[CA_IW] = take_iw || cause_nxt[CA_IW];
            cause_nxt[CA_DW] = take_dw || cause_nxt[CA_DW];
        end
        cause_nxt[CA_IP] = I_INT_PEND;
    end

    // control registers; interrupt vector select comes up clear
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            status_r <= STATUS_RST;
            cause_r <= CAUSE_RST;
            cache_policy_map_r <= CACHE_POLICY_MAP_RST;
        end else begin
            status_r <= status_nxt;
            cause_r <= cause_nxt;
            cache_policy_map_r <= we_cache_policy_map ? I_COP.wdata : cache_policy_map_r;
        end
    end

    // return addresses and faulting address, all 32 bits wide
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            epc_r <= 32'h0000_0000;
            error_return_pc_r <= 32'h0000_0000;
            faulting_address_register_r <= 32'h0000_0000;
        end else begin
            if (exc_take && !st_exl) begin
                epc_r <= exc_pc;
            end else if (we_epc) begin
                epc_r <= I_COP.wdata;
            end
            if (we_error_return_pc) begin
                error_return_pc_r <= I_COP.wdata;
            end
            if (take_ib) begin
                faulting_address_register_r <= I_IFETCH.addr;
            end else if (take_db) begin
                faulting_address_register_r <= I_DATA.addr;
            end
        end
    end

    // base/bound and watch registers; software keeps to unmapped space when changing them
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            ibase_r <= 32'h0000_0000;
            ibound_r <= 32'h0000_0000;
            dbase_r <= 32'h0000_0000;
            dbound_r <= 32'h0000_0000;
            instruction_watchpoint_r <= 32'h0000_0000;
            data_watchpoint_r <= 32'h0000_0000;
        end else begin
            ibase_r <= we_ibase ? I_COP.wdata : ibase_r;
            ibound_r <= we_ibound ? I_COP.wdata : ibound_r;
            dbase_r <= we_dbase ? I_COP.wdata : dbase_r;
            dbound_r <= we_dbound ? I_COP.wdata : dbound_r;
            instruction_watchpoint_r <= we_instruction_watchpoint ? I_COP.wdata : instruction_watchpoint_r;
            data_watchpoint_r <= we_data_watchpoint ? I_COP.wdata : data_watchpoint_r;
        end
    end

    // pending watch hits wait while an exception level is active; taking a hit consumes it,
    // but a fresh hit that lands while an older one is taken stays pending
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            iw_pend_r <= 1'b0;
            dw_pend_r <= 1'b0;
        end else begin
            iw_pend_r <= take_iw ? (iw_hit && iw_pend_r) : iw_pend;
            dw_pend_r <= take_dw ? (dw_hit && dw_pend_r) : dw_pend;
        end
    end

    // read mux; configuration is a constant, unmapped numbers read zero
    always_comb begin
        unique case (I_COP.regnum)
            REG_IBASE: rd_data = ibase_r;
            REG_IBOUND: rd_data = ibound_r;
            REG_DBASE: rd_data = dbase_r;
            REG_DBOUND: rd_data = dbound_r;
            REG_FAULTING_ADDRESS_REGISTER: rd_data = faulting_address_register_r;
            REG_STATUS: rd_data = status_r;
            REG_CAUSE: rd_data = cause_r;
            REG_EPC: rd_data = epc_r;
            REG_CONFIG: rd_data = CONFIG_VAL;
            REG_CACHE_POLICY_MAP: rd_data = cache_policy_map_r;
            REG_INSTRUCTION_WATCHPOINT: rd_data = instruction_watchpoint_r;
            REG_DATA_WATCHPOINT: rd_data = data_watchpoint_r;
            REG_ERROR_RETURN_PC: rd_data = error_return_pc_r;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // read data, translation no-op acknowledge and exception dispatch, one cycle late
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            mfc_data_r <= 32'h0000_0000;
            tlb_done_r <= 1'b0;
            exc_take_r <= 1'b0;
            exc_vector_r <= VEC_GENERAL;
            exc_code_r <= EXC_INT;
        end else begin
            mfc_data_r <= cop_rd ? rd_data : mfc_data_r;
            tlb_done_r <= I_TLB_OP;
            exc_take_r <= exc_take;
            exc_vector_r <= exc_take ? exc_vector : exc_vector_r;
            exc_code_r <= exc_take ? exc_code : exc_code_r;
        end
    end

    // fixed kernel mapping strips the segment bits; user addresses pass unchanged
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            iphys_r <= 32'h0000_0000;
            dphys_r <= 32'h0000_0000;
            ipolicy_r <= 4'h0;
            dpolicy_r <= 4'h0;
        end else begin
            iphys_r <= kernel ? (I_IFETCH.addr & KMAP_MASK) : I_IFETCH.addr;
            dphys_r <= kernel ? (I_DATA.addr & KMAP_MASK) : I_DATA.addr;
            ipolicy_r <= region_policy(cache_policy_map_r, I_IFETCH.addr);
            dpolicy_r <= region_policy(cache_policy_map_r, I_DATA.addr);
        end
    end

    // lock bits reach the victim choice immediately, well inside the allowed delay
    scc_victim_sel u_ivictim (
        .i_clk(I_CLK_SYS),
        .i_reset(I_RESET),
        .i_lock(status_r[ST_IL]),
        .i_refill(I_IREFILL),
        .o_victim_b(O_IVICTIM_B)
    );

    scc_victim_sel u_dvictim (
        .i_clk(I_CLK_SYS),
        .i_reset(I_RESET),
        .i_lock(status_r[ST_DL]),
        .i_refill(I_DREFILL),
        .o_victim_b(O_DVICTIM_B)
    );

    // two independent lanes so a multiply can run under an add
    wire fp_ok = I_FP.valid && !fp_trap;
    wire mul_busy;
    wire add_busy;
    wire fp_stall = fp_ok && (I_FP.is_mul ? mul_busy : add_busy);

    scc_fp_lane #(.LATENCY(FP_MUL_LAT)) u_fp_mul (
        .i_clk(I_CLK_SYS),
        .i_reset(I_RESET),
        .i_issue(fp_ok && I_FP.is_mul),
        .o_busy(mul_busy),
        .o_done(O_FP_MUL_DONE)
    );

    scc_fp_lane #(.LATENCY(FP_ADD_LAT)) u_fp_add (
        .i_clk(I_CLK_SYS),
        .i_reset(I_RESET),
        .i_issue(fp_ok && !I_FP.is_mul),
        .o_busy(add_busy),
        .o_done(O_FP_ADD_DONE)
    );

    // outputs
    assign O_MFC_DATA = mfc_data_r;
    assign O_TLB_DONE = tlb_done_r;
    assign O_RETURN_PC = st_erl ? error_return_pc_r : epc_r;
    assign O_FP_STALL = fp_stall;
    assign O_FP_MUL_BUSY = mul_busy;
    assign O_FP_ADD_BUSY = add_busy;
    assign O_KERNEL_MODE = kernel;
    assign O_FR_MODE = fr_mode;
    assign O_IPHYS_ADDR = iphys_r;
    assign O_DPHYS_ADDR = dphys_r;
    assign O_IPOLICY = ipolicy_r;
    assign O_DPOLICY = dpolicy_r;
    assign O_EXC_TAKE = exc_take_r;
    assign O_EXC_VECTOR = exc_vector_r;
    assign O_EXC_CODE = exc_code_r;

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);

    sequence s_dlock_write;
        we_status && I_COP.wdata[ST_DL];
    endsequence
    sequence s_dlocked_refill;
        I_DREFILL.req && I_DREFILL.valid_a && status_r[ST_DL];
    endsequence

    a_ilock_victim: assert property (
        I_IREFILL.req && status_r[ST_IL] && I_IREFILL.valid_a |=> O_IVICTIM_B)
        else $error("locked valid way A chosen for refill");
    a_invalid_refill: assert property (
        I_IREFILL.req && !I_IREFILL.valid_a |=> !O_IVICTIM_B)
        else $error("invalid way A line not refilled");
    a_dlock_effect: assert property (
        s_dlock_write ##[1:3] s_dlocked_refill |=> O_DVICTIM_B)
        else $error("data lock did not stop refill");
    a_odd_reg_trap: assert property (
        I_FP.valid && !status_r[ST_FR] && I_FP.reg_idx[0] |=> O_EXC_TAKE)
        else $error("odd float register access did not trap");
    a_int_vector_sel: assert property (
        O_EXC_TAKE && O_EXC_CODE == EXC_INT && $past(cause_r[CA_IV]) |-> O_EXC_VECTOR == VEC_INT)
        else $error("interrupt not sent to dedicated offset");
    a_general_vector: assert property (
        O_EXC_TAKE && O_EXC_CODE != EXC_INT |-> O_EXC_VECTOR == VEC_GENERAL)
        else $error("general exception at wrong offset");
    a_kernel_no_bound: assert property (
        $past(kernel) && O_EXC_TAKE |-> O_EXC_CODE != EXC_IBOUND && O_EXC_CODE != EXC_DBOUND)
        else $error("bound violation raised in kernel mode");
    a_watch_level_hold: assert property (
        $past(st_exl || st_erl) && O_EXC_TAKE |-> O_EXC_CODE != EXC_WATCH)
        else $error("watch exception taken at exception level");
    a_watch_flag_set: assert property (
        O_EXC_TAKE && O_EXC_CODE == EXC_WATCH |-> cause_r[CA_IW] || cause_r[CA_DW])
        else $error("watch exception without watch flag");
    a_bound_record: assert property (
        O_EXC_TAKE && O_EXC_CODE == EXC_IBOUND && !$past(st_exl) |-> epc_r == faulting_address_register_r)
        else $error("bound fault address not recorded");
    a_config_read: assert property (
        cop_rd && I_COP.regnum == REG_CONFIG |=> O_MFC_DATA == CONFIG_VAL)
        else $error("configuration read value wrong");
    a_policy_reset: assert property (
        $past(I_RESET) |-> cache_policy_map_r == CACHE_POLICY_MAP_RST)
        else $error("policy map reset value wrong");
endmodule : scc_ctrl

// ===== verification/scc_ctrl_tb_top.sv
// self-checking bench for the system control coprocessor
`timescale 1ns/1ps
module scc_ctrl_tb_top;
    import scc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tlb = 1'b0;
    logic eret = 1'b0;
    logic intp = 1'b0;
    scc_cop_t cop = '0;
    scc_access_t ifet = '0;
    scc_access_t dacc = '0;
    scc_fp_t fp = '0;
    scc_refill_t rf = '0;
    logic [31:0] mfc, rpc, dphys;
    logic take, tdone, ivb, dvb, kern, abusy, frm;
    logic [3:0] dpol;
    logic [11:0] vec;
    logic [5:0] code;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    // watchdog: the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            summarize();
        end
    end
    scc_ctrl DUT (.I_CLK_SYS(clk), .I_RESET(rst), .I_COP(cop), .O_MFC_DATA(mfc),
        .I_TLB_OP(tlb), .O_TLB_DONE(tdone), .I_ERET(eret), .O_RETURN_PC(rpc),
        .I_IFETCH(ifet), .I_DATA(dacc), .I_INSTR_PC(32'h0000_0400), .I_INT_PEND(intp),
        .I_FP(fp), .O_FP_STALL(), .O_FP_MUL_BUSY(), .O_FP_ADD_BUSY(abusy), .O_FP_MUL_DONE(),
        .O_FP_ADD_DONE(), .I_IREFILL(rf), .I_DREFILL(rf), .O_IVICTIM_B(ivb),
        .O_DVICTIM_B(dvb), .O_KERNEL_MODE(kern), .O_FR_MODE(frm), .O_IPHYS_ADDR(),
        .O_DPHYS_ADDR(dphys), .O_IPOLICY(), .O_DPOLICY(dpol), .O_EXC_TAKE(take),
        .O_EXC_VECTOR(vec), .O_EXC_CODE(code));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // inputs move 1 ns after the rising edge, away from the sampling point
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    // an idle cycle after each move so back-to-back moves never touch cop twice at once
    task automatic mv(input logic wr, input logic dw, input logic [4:0] rn, input logic [31:0] wd);
        cop = '{valid: 1'b1, write: wr, dword: dw, regnum: rn, wdata: wd};
        tick();
        cop = '0;
        tick();
    endtask : mv
    // bounded wait, since interrupt sampling may add a cycle
    task automatic wait_take();
        for (int i = 0; i < 4 && take !== 1'b1; i++) tick();
        chk("exc_take", 32'h1, {31'h0, take});
    endtask : wait_take
    task automatic t_reset();
        mv(1'b0, 1'b0, REG_CACHE_POLICY_MAP, 32'h0);
        chk("policy_map", 32'h2223_3333, mfc);
        mv(1'b1, 1'b0, REG_CONFIG, 32'h0);
        mv(1'b0, 1'b0, REG_CONFIG, 32'h0);
        chk("config", 32'h0000_0240, mfc);
        mv(1'b1, 1'b1, REG_CACHE_POLICY_MAP, 32'h0);
        mv(1'b0, 1'b0, REG_CACHE_POLICY_MAP, 32'h0);
        chk("dword_ignored", 32'h2223_3333, mfc);
        chk("kernel_rst", 32'h1, {31'h0, kern});
        chk("vec_rst", 32'h180, {20'h0, vec});
        // code runs from region 0, so only the top region's field is changed
        mv(1'b1, 1'b0, REG_CACHE_POLICY_MAP, 32'h5223_3333);
        dacc = '{valid: 1'b1, addr: 32'hE000_0010};
        tick();
        dacc = '0;
        chk("region_policy", 32'h5, {28'h0, dpol});
        chk("kernel_map", 32'h10, dphys);
    endtask : t_reset
    task automatic t_bound();
        mv(1'b1, 1'b0, REG_IBASE, 32'h100);
        mv(1'b1, 1'b0, REG_IBOUND, 32'h1FF);
        repeat (5) tick();
        mv(1'b1, 1'b0, REG_STATUS, 32'h10);
        ifet = '{valid: 1'b1, addr: 32'h200};
        tick();
        ifet = '0;
        wait_take();
        chk("ibound_code", 32'h2, {26'h0, code});
        chk("ibound_vec", 32'h180, {20'h0, vec});
        chk("epc", 32'h200, rpc);
        mv(1'b0, 1'b0, REG_FAULTING_ADDRESS_REGISTER, 32'h0);
        chk("faulting_address_register", 32'h200, mfc);
        ifet = '{valid: 1'b1, addr: 32'h800};
        tick();
        ifet = '0;
        tick();
        chk("kernel_no_bound", 32'h0, {31'h0, take});
    endtask : t_bound
    // interrupt with its own vector, then float traps keep the general one
    task automatic t_vec();
        mv(1'b1, 1'b0, REG_CAUSE, 32'h0080_0000);
        mv(1'b1, 1'b0, REG_STATUS, 32'h1);
        intp = 1'b1;
        wait_take();
        intp = 1'b0;
        chk("int_vec", 32'h200, {20'h0, vec});
        mv(1'b1, 1'b0, REG_STATUS, 32'h0);
        fp = '{valid: 1'b1, is_mul: 1'b0, is_double: 1'b0, is_dmove: 1'b0, reg_idx: 5'h01};
        tick();
        fp = '0;
        wait_take();
        chk("odd_reg_code", 32'h0F, {26'h0, code});
        chk("trap_vec", 32'h180, {20'h0, vec});
        mv(1'b1, 1'b0, REG_STATUS, 32'h0);
        fp = '{valid: 1'b1, is_mul: 1'b1, is_double: 1'b1, is_dmove: 1'b0, reg_idx: 5'h02};
        tick();
        fp = '0;
        wait_take();
        chk("double_code", 32'h0F, {26'h0, code});
        mv(1'b1, 1'b0, REG_STATUS, 32'h0);
        fp = '{valid: 1'b1, is_mul: 1'b0, is_double: 1'b0, is_dmove: 1'b1, reg_idx: 5'h02};
        tick();
        fp = '0;
        wait_take();
        // 32-register mode: an odd register is legal and goes to the add lane
        mv(1'b1, 1'b0, REG_STATUS, 32'h0400_0000);
        fp = '{valid: 1'b1, is_mul: 1'b0, is_double: 1'b0, is_dmove: 1'b0, reg_idx: 5'h03};
        tick();
        fp = '0;
        chk("odd_reg_fr", 32'h0, {31'h0, take});
        chk("fr_mode", 32'h1, {31'h0, frm});
        chk("add_busy", 32'h1, {31'h0, abusy});
    endtask : t_vec
    task automatic t_lock();
        mv(1'b1, 1'b0, REG_STATUS, 32'h0180_0000);
        rf = '{req: 1'b1, valid_a: 1'b1, valid_b: 1'b1, lru_b: 1'b0};
        tick();
        rf = '{req: 1'b1, valid_a: 1'b0, valid_b: 1'b1, lru_b: 1'b1};
        chk("ivictim_locked", 32'h1, {31'h0, ivb});
        chk("dvictim_locked", 32'h1, {31'h0, dvb});
        tick();
        rf = '0;
        chk("ivictim_invalid", 32'h0, {31'h0, ivb});
        tlb = 1'b1;
        tick();
        tlb = 1'b0;
        chk("tlb_done", 32'h1, {31'h0, tdone});
        chk("tlb_no_trap", 32'h0, {31'h0, take});
    endtask : t_lock
    // watch hits: taken at once with level flags clear, held while one is set
    task automatic t_watch();
        mv(1'b1, 1'b0, REG_INSTRUCTION_WATCHPOINT, 32'h0000_0301);
        ifet = '{valid: 1'b1, addr: 32'h300};
        tick();
        ifet = '0;
        wait_take();
        chk("instruction_watchpoint_code", 32'h23, {26'h0, code});
        mv(1'b0, 1'b0, REG_CAUSE, 32'h0);
        chk("cause_iw", 32'h0180_008C, mfc);
        mv(1'b1, 1'b0, REG_DATA_WATCHPOINT, 32'h0000_0501);
        dacc = '{valid: 1'b1, addr: 32'h500};
        tick();
        dacc = '0;
        tick();
        chk("watch_held", 32'h0, {31'h0, take});
        eret = 1'b1;
        tick();
        eret = 1'b0;
        wait_take();
        mv(1'b0, 1'b0, REG_CAUSE, 32'h0);
        chk("cause_dw", 32'h0380_008C, mfc);
    endtask : t_watch
    task automatic summarize();
        if (n_mismatch == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (20) tick();
        rst = 1'b0;
        t_reset();
        t_bound();
        t_vec();
        t_lock();
        t_watch();
        summarize();
    end
endmodule : scc_ctrl_tb_top
